// ===== core/fwp_core.sv
// Purpose: write protection, status lock and function register of a serial flash
// Assumes: commands arrive decoded over avalon-mm, protect pin is asynchronous
// Notes: array itself is outside; this block gives accept/refuse verdicts
`timescale 1ns/10ps
module fwp_core (
    core_clk,
    reset_n,
    avs_address,
    avs_read,
    avs_write,
    avs_writedata,
    avs_readdata,
    avs_waitrequest,
    wp_pin_n,
    hold_pin_n,
    quad_enable,
    io2_active,
    io3_active,
    hold_active,
    op_go,
    op_refused
);
    input wire logic core_clk;
    input wire logic reset_n;
    input wire logic [3:0] avs_address;
    input wire logic avs_read;
    input wire logic avs_write;
    input wire logic [31:0] avs_writedata;
    output logic [31:0] avs_readdata;
    output logic avs_waitrequest;
    input wire logic wp_pin_n;
    input wire logic hold_pin_n;
    output logic quad_enable;
    output logic io2_active;
    output logic io3_active;
    output logic hold_active;
    output logic op_go;
    output logic op_refused;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] func;
        logic [22:0] target;
        logic [1:0] row;
        logic ack;
        logic [31:0] rdata;
        logic go;
        logic refused;
        logic [1:0] last;     // bit1 go, bit0 refused of last command
        logic prog_active;
        logic erase_active;
        logic [1:0] wp_sync;
        logic [1:0] hold_sync;
    } fwp_state_t;

    fwp_state_t state_reg;
    fwp_state_t state_next;
    logic in_range;
    logic [3:0] level;
    logic wp_high;
    logic status_open;
    logic cmd_wr;
    fwp_pkg::fwp_cmd_t cmd;
    logic [7:0] wmask;

    assign level = state_reg.status[fwp_pkg::ST_LEVEL_LSB +: 4];
    assign wp_high = state_reg.wp_sync[1];
    assign cmd_wr = avs_write && (avs_address == fwp_pkg::ADDR_CMD) && !state_reg.ack;
    assign cmd = fwp_pkg::fwp_cmd_t'(avs_writedata[3:0]);

    // RULE17 block index from address bits
    fwp_range u_range (
        .level(level),
        .bottom(state_reg.func[fwp_pkg::FN_BOTTOM_BIT]),
        .blk(state_reg.target[fwp_pkg::BLK_MSB:fwp_pkg::BLK_LSB]),
        .hit(in_range)
    );

    // RULE3 unlocked always writable
    // RULE4 RULE5 lock with pin decides
    assign status_open = !state_reg.status[fwp_pkg::ST_LOCK_BIT] || wp_high;

    // RULE6 quad enable repurposes pins
    assign quad_enable = state_reg.status[fwp_pkg::ST_QUAD_BIT];
    assign io2_active = quad_enable;
    assign io3_active = quad_enable;
    assign hold_active = !quad_enable && !state_reg.hold_sync[1];
    assign op_go = state_reg.go;
    assign op_refused = state_reg.refused;
    assign avs_readdata = state_reg.rdata;
    // one wait cycle on every access, answer at second edge
    assign avs_waitrequest = (avs_read || avs_write) && !state_reg.ack;

    always_comb begin
        logic latch;
        latch = state_reg.status[fwp_pkg::ST_LATCH_BIT];
        state_next = state_reg;
        wmask = 8'h00;
        state_next.go = 1'b0;
        state_next.refused = 1'b0;
        state_next.ack = (avs_read || avs_write) && !state_reg.ack;
        // pins pass two flops; with quad on, wp reads as high
        state_next.wp_sync = {state_reg.wp_sync[0], wp_pin_n};
        state_next.hold_sync = {state_reg.hold_sync[0], hold_pin_n};
        if (quad_enable) begin
            state_next.wp_sync = 2'h3;
        end
        if (avs_write && !state_reg.ack && avs_address == fwp_pkg::ADDR_TARGET) begin
            state_next.target = avs_writedata[22:0];
            state_next.row = avs_writedata[1:0];
        end
        if (cmd_wr) begin
            unique case (cmd)
                fwp_pkg::FWP_CMD_LATCH_SET: state_next.status[fwp_pkg::ST_LATCH_BIT] = 1'b1;
                fwp_pkg::FWP_CMD_LATCH_CLR: state_next.status[fwp_pkg::ST_LATCH_BIT] = 1'b0;
                // RULE15 only this command changes status bits 7..2
                fwp_pkg::FWP_CMD_STATUS_WR: begin
                    if (latch && status_open) begin
                        wmask = avs_writedata[15:8];
                        state_next.status = {wmask[7:2], 2'b00};
                        state_next.go = 1'b1;
                    end else begin
                        state_next.refused = 1'b1;
                    end
                end
                // RULE10 RULE11 otp bits only accumulate ones
                fwp_pkg::FWP_CMD_FUNC_WR: begin
                    if (latch) begin
                        wmask = avs_writedata[15:8] & fwp_pkg::FN_OTP_MASK;
                        state_next.func = state_reg.func | wmask;
                        state_next.status[fwp_pkg::ST_LATCH_BIT] = 1'b0;
                        state_next.go = 1'b1;
                    end else begin
                        state_next.refused = 1'b1;
                    end
                end
                // RULE1 protected range refuses
                fwp_pkg::FWP_CMD_PROGRAM, fwp_pkg::FWP_CMD_ERASE: begin
                    if (latch && !in_range && !state_reg.prog_active
                        && !state_reg.erase_active) begin
                        state_next.go = 1'b1;
                        state_next.prog_active = (cmd == fwp_pkg::FWP_CMD_PROGRAM);
                        state_next.erase_active = (cmd == fwp_pkg::FWP_CMD_ERASE);
                    end else begin
                        state_next.refused = 1'b1;
                        state_next.status[fwp_pkg::ST_LATCH_BIT] = 1'b0;
                    end
                end
                // RULE2 whole erase needs zero level
                fwp_pkg::FWP_CMD_WHOLE_ERASE: begin
                    if (latch && level == 4'h0 && !state_reg.prog_active
                        && !state_reg.erase_active) begin
                        state_next.go = 1'b1;
                        state_next.erase_active = 1'b1;
                    end else begin
                        state_next.refused = 1'b1;
                        state_next.status[fwp_pkg::ST_LATCH_BIT] = 1'b0;
                    end
                end
                // RULE14 row lock forbids programming
                fwp_pkg::FWP_CMD_ROW_PROGRAM: begin
                    if (latch && !state_reg.func[fwp_pkg::FN_ROW_LSB + state_reg.row]) begin
                        state_next.go = 1'b1;
                        state_next.prog_active = 1'b1;
                    end else begin
                        state_next.refused = 1'b1;
                        state_next.status[fwp_pkg::ST_LATCH_BIT] = 1'b0;
                    end
                end
                // RULE12 RULE13 pause flags on suspend
                fwp_pkg::FWP_CMD_SUSPEND: begin
                    if (state_reg.prog_active) begin
                        state_next.func[fwp_pkg::FN_PPAUSE_BIT] = 1'b1;
                    end else if (state_reg.erase_active) begin
                        state_next.func[fwp_pkg::FN_EPAUSE_BIT] = 1'b1;
                    end
                end
                fwp_pkg::FWP_CMD_RESUME: begin
                    state_next.func[fwp_pkg::FN_PPAUSE_BIT] = 1'b0;
                    state_next.func[fwp_pkg::FN_EPAUSE_BIT] = 1'b0;
                end
                // RULE16 latch clears on completion
                fwp_pkg::FWP_CMD_DONE: begin
                    state_next.status[fwp_pkg::ST_LATCH_BIT] = 1'b0;
                    state_next.prog_active = 1'b0;
                    state_next.erase_active = 1'b0;
                    state_next.func[fwp_pkg::FN_PPAUSE_BIT] = 1'b0;
                    state_next.func[fwp_pkg::FN_EPAUSE_BIT] = 1'b0;
                end
                default: ;
            endcase
            state_next.last = {state_next.go, state_next.refused};
        end
        // read mux, unmapped reads zero
        if (avs_read && !state_reg.ack) begin
            unique case (avs_address)
                fwp_pkg::ADDR_STATUS: state_next.rdata = {24'h000000, state_reg.status};
                fwp_pkg::ADDR_FUNC: state_next.rdata = {24'h000000, state_reg.func};
                fwp_pkg::ADDR_TARGET: state_next.rdata = {9'h000, state_reg.target};
                fwp_pkg::ADDR_RESULT: state_next.rdata = {27'h0, state_reg.erase_active,
                    state_reg.prog_active, in_range, state_reg.last};
                fwp_pkg::ADDR_PINS: state_next.rdata = {30'h0, state_reg.hold_sync[1], wp_high};
                default: state_next.rdata = 32'h00000000;
            endcase
        end
    end

    // whole state in one register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '{status: fwp_pkg::STATUS_RESET, func: fwp_pkg::FUNC_RESET,
                wp_sync: 2'h3, hold_sync: 2'h3, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    // RULE4 locked status must not change
    a_status_locked: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state_reg.status[7] && !wp_high && !state_reg.ack)
        |=> state_reg.status[7:2] == $past(state_reg.status[7:2])) // RULE4
        else $error("status changed while locked");
    // RULE2 whole erase refused on level
    a_whole_erase: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cmd_wr && cmd == fwp_pkg::FWP_CMD_WHOLE_ERASE && level != 4'h0)
        |=> op_refused && !op_go) // RULE2
        else $error("whole erase not refused");
    // RULE1 program in range refused
    a_range_refuse: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cmd_wr && cmd == fwp_pkg::FWP_CMD_PROGRAM && in_range) |=> !op_go) // RULE1
        else $error("protected program accepted");
    // RULE11 otp bits never fall
    a_otp_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
        ($past(state_reg.func[7:4]) & ~state_reg.func[7:4]) == 4'h0) // RULE11
        else $error("otp lock bit cleared");
    // RULE10 bottom select sticks
    a_bottom_kept: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(state_reg.func[1]) |-> state_reg.func[1]) // RULE10
        else $error("bottom select cleared");
    // RULE9 high level bit covers all
    a_full_cover: assert property (@(posedge core_clk) disable iff (!reset_n)
        level[3] |-> in_range) // RULE9
        else $error("full level not protecting");
    // RULE12 suspend during program
    a_prog_pause: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cmd_wr && cmd == fwp_pkg::FWP_CMD_SUSPEND && state_reg.prog_active)
        |=> state_reg.func[2] ##1 state_reg.func[2] || $past(cmd_wr)) // RULE12
        else $error("program pause flag not set");
    // RULE13 suspend during erase
    a_erase_pause: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cmd_wr && cmd == fwp_pkg::FWP_CMD_SUSPEND && !state_reg.prog_active
        && state_reg.erase_active) |=> state_reg.func[3]) // RULE13
        else $error("erase pause flag not set");
    // RULE6 quad mode pin roles
    a_quad_pins: assert property (@(posedge core_clk) disable iff (!reset_n)
        quad_enable |-> io2_active && !hold_active) // RULE6
        else $error("quad pins not repurposed");
    // RULE16 no go without latch
    a_latch_needed: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cmd_wr && !state_reg.status[1] && cmd != fwp_pkg::FWP_CMD_LATCH_SET) |=> !op_go) // RULE16
        else $error("operation without write latch");
endmodule // fwp_core

// ===== core/fwp_pkg.sv
// Purpose: constants for the flash write-protect and function register block
// Assumes: avalon-mm word addressing, 32-bit data, one clock
// Notes: status and function registers held in flops, reset to factory default
// Function
// RULE1 - refuse program/erase inside protected blocks
// RULE2 - whole erase only when level is zero
// RULE3 - lock zero: status writes always accepted
// RULE4 - lock one, pin low: status write ignored
// RULE5 - lock one, pin high: status write accepted
// RULE6 - quad enable repurposes protect/hold pins
// RULE7 - top mode protects 2^(n-1) blocks downward
// RULE8 - bottom mode counts upward from block 0
// RULE9 - level bit3 set protects all blocks
// RULE10 - bottom select never returns to zero
// RULE11 - otp bits stay one forever
// RULE12 - program paused flag set/clear by suspend/resume
// RULE13 - erase paused flag set/clear by suspend/resume
// RULE14 - info row locks forbid row programming
// RULE15 - status bits nonvolatile, changed only by write
// RULE16 - write latch needed, cleared after operation
// RULE17 - block index from address bits 22..16
package fwp_pkg;
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_FUNC = 4'h1;
    localparam logic [3:0] ADDR_CMD = 4'h2;
    localparam logic [3:0] ADDR_TARGET = 4'h3;
    localparam logic [3:0] ADDR_RESULT = 4'h4;
    localparam logic [3:0] ADDR_PINS = 4'h5;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] FUNC_RESET = 8'h00;
    localparam int ST_LATCH_BIT = 1;
    localparam int ST_LEVEL_LSB = 2;
    localparam int ST_QUAD_BIT = 6;
    localparam int ST_LOCK_BIT = 7;
    localparam int FN_BOTTOM_BIT = 1;
    localparam int FN_PPAUSE_BIT = 2;
    localparam int FN_EPAUSE_BIT = 3;
    localparam int FN_ROW_LSB = 4;
    localparam int BLK_MSB = 22;
    localparam int BLK_LSB = 16;
    localparam logic [7:0] FN_OTP_MASK = 8'hf2;
    localparam int CHECK_CYCLES = 1;
    typedef enum logic [3:0] {
        FWP_CMD_NONE = 4'h0,
        FWP_CMD_LATCH_SET = 4'h1,
        FWP_CMD_LATCH_CLR = 4'h2,
        FWP_CMD_STATUS_WR = 4'h3,
        FWP_CMD_FUNC_WR = 4'h4,
        FWP_CMD_PROGRAM = 4'h5,
        FWP_CMD_ERASE = 4'h6,
        FWP_CMD_WHOLE_ERASE = 4'h7,
        FWP_CMD_ROW_PROGRAM = 4'h8,
        FWP_CMD_SUSPEND = 4'h9,
        FWP_CMD_RESUME = 4'ha,
        FWP_CMD_DONE = 4'hb
    } fwp_cmd_t;
endpackage

// ===== core/fwp_range.sv
// Purpose: decide whether a 64 KB block index lies in the protected region
// Assumes: 128 blocks, four-bit level, bottom select from function register
// Notes: purely combinational
`timescale 1ns/10ps
module fwp_range (
    input wire logic [3:0] level,
    input wire logic bottom,
    input wire logic [6:0] blk,
    output logic hit
);
    logic [7:0] count;
    // RULE7 block count per level
    always_comb begin
        if (level[2:0] == 3'h0) begin
            count = 8'h00;
        end else begin
            count = 8'h01 << (level[2:0] - 3'h1);
        end
    end
    // RULE9 top level bit covers all
    // RULE8 bottom counts upward
    always_comb begin
        if (level[3]) begin
            hit = 1'b1;
        end else if (bottom) begin
            hit = ({1'b0, blk} < count);
        end else begin
            hit = ({1'b0, blk} >= (8'h80 - count));
        end
    end
endmodule // fwp_range

// ===== verif/fwp_host.sv
// Purpose: host controller model issuing flash commands over the register bus
// Assumes: slave decides its own wait states; caller enters just after a rising edge
// Notes: request held until waitrequest is seen low; released data lines invert
`timescale 1ns/10ps
module fwp_host (
    input wire logic core_clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic op_go,
    input wire logic op_refused,
    output logic [3:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata
);
    // idle bus from time zero
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end

    // one access; verdict pulses are taken at the completing edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] p);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        p = {op_go, op_refused};
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        avs_writedata <= ~d; // stale data must not look valid
        @(posedge core_clk);
    endtask

    // bare command, no latch set ahead
    task automatic cmd(input fwp_pkg::fwp_cmd_t c, input logic [7:0] v,
                       output logic [1:0] p);
        logic [31:0] q;
        acc(1'b1, fwp_pkg::ADDR_CMD, {16'h0, v, 4'h0, c}, q, p);
    endtask

    task automatic go(input fwp_pkg::fwp_cmd_t c, input logic [7:0] v,
                      output logic [1:0] p);
        cmd(fwp_pkg::FWP_CMD_LATCH_SET, 8'h00, p);
        cmd(c, v, p);
    endtask
endmodule // fwp_host

// ===== verif/tb_flash_write_protect_and_function_reg.sv
// Purpose: self-checking bench for the write-protect and function register block
// Assumes: two-cycle bus accesses, pins need a few edges to sync
// Notes: protection expectations are worked out from the level table here
`timescale 1ns/10ps
module tb_flash_write_protect_and_function_reg;
    logic core_clk;
    logic reset_n;
    logic wp_pin_n;
    logic hold_pin_n;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic quad_enable;
    logic io2_active;
    logic io3_active;
    logic hold_active;
    logic op_go;
    logic op_refused;
    logic [31:0] q;
    logic [1:0] p;
    int miscompares;
    int cmp_count;
    int cycles;
    int blks [8] = '{0, 1, 3, 63, 64, 96, 126, 127};

    fwp_core i_dut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .wp_pin_n(wp_pin_n), .hold_pin_n(hold_pin_n), .quad_enable(quad_enable),
        .io2_active(io2_active), .io3_active(io3_active), .hold_active(hold_active),
        .op_go(op_go), .op_refused(op_refused));
    fwp_host i_host (.core_clk(core_clk), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .op_go(op_go), .op_refused(op_refused),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata));

    // 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // hang guard, well above three full sweeps
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string m);
        i_host.acc(1'b0, a, 32'h0, q, p);
        chk(q, e, m);
    endtask

    // accepted commands are closed with done so no operation stays active
    task automatic ok_if(input logic e, input string m);
        chk({30'h0, p}, e ? 32'h2 : 32'h1, m);
        if (p[1]) i_host.cmd(fwp_pkg::FWP_CMD_DONE, 8'h00, p);
    endtask

    task automatic st(input logic [7:0] v);
        i_host.go(fwp_pkg::FWP_CMD_STATUS_WR, v, p);
    endtask

    task automatic tgt(input logic [22:0] a);
        i_host.acc(1'b1, fwp_pkg::ADDR_TARGET, {9'h0, a}, q, p);
    endtask

    // expected protection of one 64 KB block
    function automatic logic prot(input logic [3:0] l, input logic b, input int k);
        int c;
        c = (l == 4'h0) ? 0 : (1 << (l - 1));
        if (l[3]) return 1'b1;
        return b ? (k < c) : (k >= 128 - c);
    endfunction

    // every level, whole erase and a set of boundary blocks
    task automatic sweep(input logic b);
        for (int l = 0; l < 16; l++) begin
            st({2'b00, 4'(l), 2'b00});
            rd(fwp_pkg::ADDR_STATUS, {26'h0, 4'(l), 2'b00}, "level");
            i_host.go(fwp_pkg::FWP_CMD_WHOLE_ERASE, 8'h00, p);
            ok_if(l == 0, "whole erase");
            for (int i = 0; i < 8; i++) begin
                tgt({7'(blks[i]), 16'hffff});
                i_host.go(i[0] ? fwp_pkg::FWP_CMD_ERASE : fwp_pkg::FWP_CMD_PROGRAM, 8'h00, p);
                ok_if(!prot(4'(l), b, blks[i]), "block");
            end
        end
    endtask

    // pin change then let the synchroniser settle
    task automatic pins(input logic w, input logic h);
        wp_pin_n <= w;
        hold_pin_n <= h;
        repeat (3) @(posedge core_clk);
    endtask

    // main sequence
    initial begin
        reset_n = 1'b0;
        wp_pin_n = 1'b1;
        hold_pin_n = 1'b1;
        miscompares = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(fwp_pkg::ADDR_STATUS, 32'h0, "status reset");
        rd(fwp_pkg::ADDR_FUNC, 32'h0, "function reset");
        rd(4'hf, 32'h0, "unmapped read");
        i_host.acc(1'b1, 4'hf, 32'hffffffff, q, p);
        i_host.cmd(fwp_pkg::FWP_CMD_STATUS_WR, 8'hfc, p);
        ok_if(1'b0, "no latch");
        rd(fwp_pkg::ADDR_STATUS, 32'h0, "write without latch");
        sweep(1'b0);
        sweep(1'b0);
        st(8'h80);
        rd(fwp_pkg::ADDR_STATUS, 32'h80, "lock set");
        pins(1'b0, 1'b1);
        rd(fwp_pkg::ADDR_PINS, 32'h2, "pin sync");
        st(8'h88);
        ok_if(1'b0, "locked write");
        // an ignored status write never completes, so the write latch stays set
        rd(fwp_pkg::ADDR_STATUS, 32'h82, "locked, pin low");
        pins(1'b1, 1'b1);
        st(8'h84);
        ok_if(1'b1, "unlocked by pin");
        rd(fwp_pkg::ADDR_STATUS, 32'h84, "locked, pin high");
        st(8'h00);
        pins(1'b0, 1'b0);
        st(8'h04);
        rd(fwp_pkg::ADDR_STATUS, 32'h04, "unlocked, pin low");
        @(negedge core_clk);
        chk({28'h0, quad_enable, io2_active, io3_active, hold_active}, 32'h1, "pins");
        @(posedge core_clk);
        st(8'h40);
        @(negedge core_clk);
        chk({28'h0, quad_enable, io2_active, io3_active, hold_active}, 32'he, "quad");
        @(posedge core_clk);
        st(8'h00);
        pins(1'b1, 1'b1);
        tgt(23'h0);
        for (int e = 0; e < 2; e++) begin
            i_host.go(e ? fwp_pkg::FWP_CMD_ERASE : fwp_pkg::FWP_CMD_PROGRAM, 8'h00, p);
            i_host.cmd(fwp_pkg::FWP_CMD_SUSPEND, 8'h00, p);
            rd(fwp_pkg::ADDR_RESULT, e ? 32'h10 : 32'h08, "active op");
            rd(fwp_pkg::ADDR_FUNC, e ? 32'h8 : 32'h4, "paused");
            i_host.cmd(fwp_pkg::FWP_CMD_RESUME, 8'h00, p);
            rd(fwp_pkg::ADDR_FUNC, 32'h0, "resumed");
            i_host.cmd(fwp_pkg::FWP_CMD_DONE, 8'h00, p);
        end
        i_host.go(fwp_pkg::FWP_CMD_FUNC_WR, 8'h02, p);
        rd(fwp_pkg::ADDR_FUNC, 32'h02, "bottom set");
        i_host.go(fwp_pkg::FWP_CMD_FUNC_WR, 8'h00, p);
        rd(fwp_pkg::ADDR_FUNC, 32'h02, "bottom kept");
        sweep(1'b1);
        st(8'h00);
        i_host.go(fwp_pkg::FWP_CMD_FUNC_WR, 8'h10, p);
        rd(fwp_pkg::ADDR_FUNC, 32'h12, "row lock");
        for (int r = 0; r < 2; r++) begin
            tgt(23'(r));
            i_host.go(fwp_pkg::FWP_CMD_ROW_PROGRAM, 8'h00, p);
            ok_if(r == 1, "row program");
        end
        wrap_up();
    end
endmodule // tb_flash_write_protect_and_function_reg
